// >>> gpm_top.sv
// general-purpose pin bank with native function mux, events and straps
// What this block does
// - every implemented pin in general use programs as input or output
// - inputs 0 to 15 raise system-mgmt or acpi interrupt, never both
// - pins 2 to 5 are open-drain, default input, shared with pci irq e-h
// - pin 24 config survives the software-triggered system reset
// - pin 26 function chosen by power-mgmt config bit 8, not select bit
// - pin 58 function chosen by flash map bits 9:8, not select bit
// - listed pins default to native function after reset
// - listed pins default to general input after reset
// - listed pins default to general output; pin 24 may show memory activity
// - pin 16 native on mobile, general output on desktop
// - on mobile pins 32, 25, 15 are native only
// - native function on a pin depends on platform variant
// - pins 58,55,53,51,49,20 sampled as straps at reset release
`timescale 1ns/1ps
`include "gpm_defines.svh"
module gpm_top (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SUS_RESET_N,
  input wire logic MOBILE,
  input wire logic [60:0] WELL_SUS,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [60:0] PAD_I,
  output logic [60:0] PAD_O,
  output logic [60:0] PAD_OE,
  input wire logic [60:0] NATIVE_O,
  input wire logic [60:0] NATIVE_OE,
  output logic [60:0] NATIVE_I,
  input wire logic MEM_ACTIVITY,
  output logic SYSTEM_MGMT_INTERRUPT,
  output logic ACPI_CONTROL_INTERRUPT,
  output logic IRQ
);
  logic rst_meta_q, rst_n;
  logic srst_meta_q, srst_n;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end
  always_ff @(posedge CLK or negedge SUS_RESET_N) begin
    if (!SUS_RESET_N) begin
      srst_meta_q <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      srst_meta_q <= 1'b1;
      srst_n <= srst_meta_q;
    end
  end

  gpm_pkg::gpm_pins_t pad_s, well_s;
  logic [1:0] mob_s;
  gpm_sync #(.W(61)) u_pad (.clk(CLK), .rst_n(rst_n), .d(PAD_I), .q(pad_s));
  gpm_sync #(.W(61)) u_well (.clk(CLK), .rst_n(rst_n), .d(WELL_SUS), .q(well_s));
  gpm_sync #(.W(2)) u_mob (.clk(CLK), .rst_n(rst_n), .d({MOBILE, 1'b0}), .q(mob_s));
  wire logic mobile = mob_s[1];

  // bus request bundle
  gpm_pkg::gpm_wb_req_s req;
  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, sel: WB_SEL_I, adr: WB_ADR_I, dat: WB_DAT_I};
  gpm_pkg::gpm_bus_e bus_q, bus_d;
  logic hit;
  assign hit = req.cyc && req.stb && (bus_q == gpm_pkg::GPM_SW_IDLE);
  logic wr;
  assign wr = hit && req.we;

  // byte-enable write mask
  logic [31:0] bmask;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{req.sel[i]}};
    end
  end

  // register write strobes over the 61-bit pin vectors
  gpm_pkg::gpm_pins_t wdat, wm_sel, wm_dir, wm_lvl;
  always_comb begin
    wdat = {req.dat[28:0], req.dat};
    wm_sel = '0;
    wm_dir = '0;
    wm_lvl = '0;
    if (wr && req.adr == `GPM_SEL_LO) begin
      wm_sel[31:0] = bmask;
    end else if (wr && req.adr == `GPM_SEL_HI) begin
      wm_sel[60:32] = bmask[28:0];
    end else if (wr && req.adr == `GPM_DIR_LO) begin
      wm_dir[31:0] = bmask;
    end else if (wr && req.adr == `GPM_DIR_HI) begin
      wm_dir[60:32] = bmask[28:0];
    end else if (wr && req.adr == `GPM_LVL_LO) begin
      wm_lvl[31:0] = bmask;
    end else if (wr && req.adr == `GPM_LVL_HI) begin
      wm_lvl[60:32] = bmask[28:0];
    end
  end

  // misc control registers
  logic [15:0] route_q, route_d, evt_en_q, evt_en_d, evt_q, evt_d;
  logic pm_s4_q, pm_s4_d, swrst_q, swrst_d;
  logic [1:0] flmap_q, flmap_d;
  logic [5:0] strap_q, strap_d;
  logic strap_done_q, strap_done_d;
  // counts the first edges after release so that defaults and straps see synchronised pads
  logic [1:0] boot_q, boot_d;
  logic [15:0] gi_q, gi_d;
  logic [31:0] rdat_q, rdat_d;

  gpm_pkg::gpm_pins_t impl, sel_init, sel_c, dir_c, lvl_c, sel_s, dir_s, lvl_s;
  gpm_pkg::gpm_pins_t gp_sel, keep;
  assign impl = mobile ? `GPM_IMPL_MB : `GPM_IMPL_DT;
  assign sel_init = mobile ? `GPM_SEL_RST_MB : `GPM_SEL_RST_DT;
  assign keep = 61'h1 << `GPM_PIN_MEMLED;

  // core-well and suspend-well copies, each on its own reset
  gpm_pin_cfg u_core (
    .clk(CLK), .rst_n(rst_n), .init(swrst_q | ~strap_done_q), .sel_init(sel_init),
    .keep(strap_done_q ? keep : 61'h0), .well(~well_s), .wr_sel_m(wm_sel), .wr_dir_m(wm_dir), .wr_lvl_m(wm_lvl),
    .wdat(wdat), .sel_q(sel_c), .dir_q(dir_c), .lvl_q(lvl_c)
  );
  // suspend copy keeps loading until its well map has come through the synchroniser
  logic [1:0] sus_cnt_q, sus_cnt_d;
  logic sus_init;
  always_comb begin
    sus_cnt_d = (sus_cnt_q == 2'h3) ? sus_cnt_q : sus_cnt_q + 2'h1;
    sus_init = (sus_cnt_q != 2'h3);
  end
  always_ff @(posedge CLK or negedge srst_n) begin
    if (!srst_n) begin
      sus_cnt_q <= 2'h0;
    end else begin
      sus_cnt_q <= sus_cnt_d;
    end
  end
  // a power-up load restores every pin, pin 24 included; only the soft reset spares it
  gpm_pin_cfg u_sus (
    .clk(CLK), .rst_n(srst_n), .init(swrst_q | sus_init), .sel_init(sel_init),
    .keep(sus_init ? 61'h0 : keep), .well(well_s), .wr_sel_m(wm_sel), .wr_dir_m(wm_dir), .wr_lvl_m(wm_lvl),
    .wdat(wdat), .sel_q(sel_s), .dir_q(dir_s), .lvl_q(lvl_s)
  );

  gpm_pkg::gpm_pins_t sel, dir, lvl;
  always_comb begin
    sel = ((sel_c & ~well_s) | (sel_s & well_s)) & impl;
    dir = (dir_c & ~well_s) | (dir_s & well_s);
    lvl = (lvl_c & ~well_s) | (lvl_s & well_s);
    gp_sel = sel;
    gp_sel[`GPM_PIN_S4] = pm_s4_q;
    // a zero map means no second flash part, leaving the pin free for general use
    gp_sel[`GPM_PIN_FCS1] = (flmap_q == 2'b00) && impl[`GPM_PIN_FCS1];
  end

  // pad drive: general output drives its stored level, otherwise native function
  gpm_pkg::gpm_pins_t gen_out, od_lvl;
  always_comb begin
    gen_out = lvl;
    gen_out[`GPM_PIN_MEMLED] = lvl[`GPM_PIN_MEMLED] | MEM_ACTIVITY;
    od_lvl = gen_out & ~`GPM_OD_MASK;
    PAD_O = (gp_sel & od_lvl) | (~gp_sel & NATIVE_O & ~`GPM_OD_MASK);
    // open-drain pins only drive low
    PAD_OE = (gp_sel & ~dir & (~`GPM_OD_MASK | ~gen_out)) | (~gp_sel & NATIVE_OE);
    NATIVE_I = pad_s & ~gp_sel;
  end

  // event logic on inputs 0..15
  logic [15:0] gi_rise;
  logic evt_clr;
  // no edges until the synchronised pads and the edge history hold real levels
  assign gi_rise = pad_s[15:0] & ~gi_q & gp_sel[15:0] & dir[15:0] & {16{strap_done_q}};
  assign evt_clr = wr && req.adr == `GPM_EVT_CLR;

  always_comb begin
    bus_d = gpm_pkg::GPM_SW_IDLE;
    route_d = route_q;
    evt_en_d = evt_en_q;
    pm_s4_d = pm_s4_q;
    flmap_d = flmap_q;
    swrst_d = 1'b0;
    strap_d = strap_q;
    boot_d = (boot_q == 2'h3) ? boot_q : boot_q + 2'h1;
    strap_done_d = strap_done_q | (boot_q == 2'h2);
    gi_d = pad_s[15:0];
    rdat_d = rdat_q;
    // set wins over a clear in the same cycle
    evt_d = (evt_q & ~(evt_clr ? (req.dat[15:0] & bmask[15:0]) : 16'h0)) | gi_rise;
    if (!strap_done_q) begin
      strap_d = {pad_s[58], pad_s[55], pad_s[53], pad_s[51], pad_s[49], pad_s[20]};
    end
    if (hit) begin
      bus_d = gpm_pkg::GPM_SW_ACK;
      rdat_d = 32'h0;
      if (req.we) begin
        if (req.adr == `GPM_ROUTE) begin
          route_d = (route_q & ~bmask[15:0]) | (req.dat[15:0] & bmask[15:0]);
        end else if (req.adr == `GPM_EVT_EN) begin
          evt_en_d = (evt_en_q & ~bmask[15:0]) | (req.dat[15:0] & bmask[15:0]);
        end else if (req.adr == `GPM_PMCFG && req.sel[1]) begin
          pm_s4_d = req.dat[`GPM_PMCFG_S4_BIT];
        end else if (req.adr == `GPM_FLMAP && req.sel[1]) begin
          flmap_d = req.dat[`GPM_FLMAP_LO_BIT +: 2];
        end else if (req.adr == `GPM_CTRL && req.sel[0]) begin
          swrst_d = req.dat[`GPM_CTRL_SWRST_BIT];
        end
      end else begin
        if (req.adr == `GPM_SEL_LO) begin
          rdat_d = gp_sel[31:0];
        end else if (req.adr == `GPM_SEL_HI) begin
          rdat_d = {3'h0, gp_sel[60:32]};
        end else if (req.adr == `GPM_DIR_LO) begin
          rdat_d = dir[31:0];
        end else if (req.adr == `GPM_DIR_HI) begin
          rdat_d = {3'h0, dir[60:32]};
        end else if (req.adr == `GPM_LVL_LO) begin
          rdat_d = lvl[31:0];
        end else if (req.adr == `GPM_LVL_HI) begin
          rdat_d = {3'h0, lvl[60:32]};
        end else if (req.adr == `GPM_IN_LO) begin
          rdat_d = pad_s[31:0];
        end else if (req.adr == `GPM_IN_HI) begin
          rdat_d = {3'h0, pad_s[60:32]};
        end else if (req.adr == `GPM_ROUTE) begin
          rdat_d = {16'h0, route_q};
        end else if (req.adr == `GPM_EVT_STS) begin
          rdat_d = {16'h0, evt_q};
        end else if (req.adr == `GPM_EVT_EN) begin
          rdat_d = {16'h0, evt_en_q};
        end else if (req.adr == `GPM_PMCFG) begin
          rdat_d = {23'h0, pm_s4_q, 8'h0};
        end else if (req.adr == `GPM_FLMAP) begin
          rdat_d = {22'h0, flmap_q, 8'h0};
        end else if (req.adr == `GPM_STRAP) begin
          rdat_d = {26'h0, strap_q};
        end else if (req.adr == `GPM_CTRL) begin
          rdat_d = {30'h0, mobile, 1'b0};
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= gpm_pkg::GPM_SW_IDLE;
      route_q <= 16'h0;
      evt_en_q <= 16'h0;
      evt_q <= 16'h0;
      pm_s4_q <= 1'b0;
      flmap_q <= 2'b00;
      swrst_q <= 1'b0;
      strap_q <= 6'h00;
      strap_done_q <= 1'b0;
      boot_q <= 2'h0;
      gi_q <= 16'h0;
      rdat_q <= 32'h0;
    end else begin
      bus_q <= bus_d;
      route_q <= route_d;
      evt_en_q <= evt_en_d;
      evt_q <= evt_d;
      pm_s4_q <= pm_s4_d;
      flmap_q <= flmap_d;
      swrst_q <= swrst_d;
      strap_q <= strap_d;
      strap_done_q <= strap_done_d;
      boot_q <= boot_d;
      gi_q <= gi_d;
      rdat_q <= rdat_d;
    end
  end

  // each enabled event raises IRQ and exactly one of the other two interrupts by its route bit
  logic [15:0] evt_on;
  assign evt_on = evt_q & evt_en_q;
  assign SYSTEM_MGMT_INTERRUPT = |(evt_on & ~route_q);
  assign ACPI_CONTROL_INTERRUPT = |(evt_on & route_q);
  assign IRQ = |evt_on;
  assign WB_ACK_O = (bus_q == gpm_pkg::GPM_SW_ACK);
  assign WB_DAT_O = rdat_q;
endmodule

// >>> gpm_defines.svh
// register offsets, field positions, reset values and pin tables for the pin mux
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH
`define GPM_NPIN 61
`define GPM_ADDR_W 8
// register byte addresses (word aligned)
`define GPM_SEL_LO 8'h00
`define GPM_SEL_HI 8'h04
`define GPM_DIR_LO 8'h08
`define GPM_DIR_HI 8'h0c
`define GPM_LVL_LO 8'h10
`define GPM_LVL_HI 8'h14
`define GPM_IN_LO 8'h18
`define GPM_IN_HI 8'h1c
`define GPM_ROUTE 8'h20
`define GPM_EVT_STS 8'h24
`define GPM_EVT_CLR 8'h28
`define GPM_EVT_EN 8'h2c
`define GPM_PMCFG 8'h30
`define GPM_FLMAP 8'h34
`define GPM_STRAP 8'h38
`define GPM_CTRL 8'h3c
// field positions
`define GPM_PMCFG_S4_BIT 8
`define GPM_FLMAP_LO_BIT 8
`define GPM_CTRL_SWRST_BIT 0
`define GPM_CTRL_MOBILE_BIT 1
`define GPM_PIN_MEMLED 24
`define GPM_PIN_S4 26
`define GPM_PIN_FCS1 58
// reset values and pin masks, bit n = pin n; sel 1 = general use, dir 1 = input
`define GPM_SEL_RST_DT 61'h0703_00ff_197f_75ff
`define GPM_SEL_RST_MB 61'h0703_00fe_197e_65ff
`define GPM_DIR_RST 61'h0701_00f0_006a_65ff
`define GPM_IMPL_MB 61'h1fff_fffe_fdff_7fff
`define GPM_IMPL_DT 61'h1fff_ffff_ffff_ffff
`define GPM_OD_MASK 61'h0000_0000_0000_003c
`define GPM_STRAP_MASK 61'h04aa_0000_0010_0000
`endif

// >>> gpm_pkg.sv
// types shared by the pin mux files
package gpm_pkg;
  typedef logic [60:0] gpm_pins_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } gpm_wb_req_s;
  typedef enum logic [1:0] {
    GPM_SW_IDLE = 2'b00,
    GPM_SW_ACK = 2'b01
  } gpm_bus_e;
endpackage

// >>> gpm_sync.sv
// two flip-flop synchroniser for the pad inputs
`timescale 1ns/1ps
module gpm_sync #(
  parameter int W = 61
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> gpm_pin_cfg.sv
// per-pin configuration state of one power well with its own reset
`timescale 1ns/1ps
`include "gpm_defines.svh"
module gpm_pin_cfg (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic init,
  input wire gpm_pkg::gpm_pins_t sel_init,
  input wire gpm_pkg::gpm_pins_t keep,
  input wire gpm_pkg::gpm_pins_t well,
  input wire gpm_pkg::gpm_pins_t wr_sel_m,
  input wire gpm_pkg::gpm_pins_t wr_dir_m,
  input wire gpm_pkg::gpm_pins_t wr_lvl_m,
  input wire gpm_pkg::gpm_pins_t wdat,
  output gpm_pkg::gpm_pins_t sel_q,
  output gpm_pkg::gpm_pins_t dir_q,
  output gpm_pkg::gpm_pins_t lvl_q
);
  gpm_pkg::gpm_pins_t sel_d, dir_d, lvl_d, clr;
  always_comb begin
    clr = init ? (well & ~keep) : '0;
    sel_d = (sel_q & ~(wr_sel_m & well)) | (wdat & wr_sel_m & well);
    dir_d = (dir_q & ~(wr_dir_m & well)) | (wdat & wr_dir_m & well);
    lvl_d = (lvl_q & ~(wr_lvl_m & well)) | (wdat & wr_lvl_m & well);
    // soft reset restores defaults except for kept pins
    sel_d = (sel_d & ~clr) | (sel_init & clr);
    dir_d = (dir_d & ~clr) | (`GPM_DIR_RST & clr);
    lvl_d = lvl_d & ~clr;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= '0;
      dir_q <= '1;
      lvl_q <= '0;
    end else begin
      sel_q <= sel_d;
      dir_q <= dir_d;
      lvl_q <= lvl_d;
    end
  end
endmodule

// >>> gpm_properties.sv
// concurrent checks on the pin bank ports, bound to the top module
`timescale 1ns/1ps
`include "gpm_defines.svh"
module gpm_properties (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic MOBILE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [60:0] PAD_O,
  input wire logic [60:0] PAD_OE,
  input wire logic [60:0] NATIVE_OE,
  input wire logic SYSTEM_MGMT_INTERRUPT,
  input wire logic ACPI_CONTROL_INTERRUPT,
  input wire logic IRQ
);
  logic [3:0] up_q;
  logic [3:0] up_d;
  logic [60:0] gen;
  logic chk;
  // defaults are judged once, well after both flops and the init load have settled
  always_comb begin
    up_d = (up_q == 4'hf) ? up_q : up_q + 4'h1;
    gen = MOBILE ? `GPM_SEL_RST_MB : `GPM_SEL_RST_DT;
    chk = (up_q == 4'h6);
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      up_q <= 4'h0;
    end else begin
      up_q <= up_d;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  ack_next_cycle_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acked in the next cycle");
  ack_needs_req_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O) else $error("ack without request");
  native_default_a: assert property (chk |-> ((PAD_OE ^ NATIVE_OE) & ~gen) == 61'h0)
    else $error("native pin not following native enable");
  input_default_a: assert property (chk |-> (PAD_OE & gen & `GPM_DIR_RST) == 61'h0)
    else $error("default input pin driving");
  output_default_a: assert property (chk |-> (PAD_OE | ~gen | `GPM_DIR_RST) == {61{1'b1}})
    else $error("default output pin not driving");
  open_drain_a: assert property ((PAD_OE & PAD_O & `GPM_OD_MASK) == 61'h0)
    else $error("open-drain pin driven high");
  quiet_default_a: assert property (chk |-> !IRQ && !SYSTEM_MGMT_INTERRUPT && !ACPI_CONTROL_INTERRUPT)
    else $error("interrupt active after reset");
endmodule
bind gpm_top gpm_properties u_props (.CLK(CLK), .RESET_N(RESET_N), .MOBILE(MOBILE), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .PAD_O(PAD_O), .PAD_OE(PAD_OE), .NATIVE_OE(NATIVE_OE),
  .SYSTEM_MGMT_INTERRUPT(SYSTEM_MGMT_INTERRUPT), .ACPI_CONTROL_INTERRUPT(ACPI_CONTROL_INTERRUPT), .IRQ(IRQ));

// >>> gpm_board.sv
// board model: resolves each pad from the pin bank, board drivers and pull-ups
`timescale 1ns/1ps
module gpm_board (
  input wire logic [60:0] pad_o,
  input wire logic [60:0] pad_oe,
  input wire logic [60:0] ext_lvl,
  input wire logic [60:0] ext_en,
  output logic [60:0] pad_i
);
  always_comb begin
    for (int k = 0; k < 61; k++) begin
      if (pad_oe[k]) begin
        pad_i[k] = pad_o[k];
      end else if (ext_en[k]) begin
        pad_i[k] = ext_lvl[k];
      end else begin
        pad_i[k] = 1'b1; // released pads rest at the inactive high level
      end
    end
  end
endmodule

// >>> general_purpose_io_pin_mux_tb.sv
// self-checking bench for the pin bank: bus, defaults, events, resets, straps
`timescale 1ns/1ps
`include "gpm_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module general_purpose_io_pin_mux_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sus_n = 1'b0;
  logic mobile = 1'b0;
  logic mem_act = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [60:0] wsus = '0;
  logic [60:0] nat_o = '0;
  logic [60:0] nat_oe = '0;
  logic [60:0] ext_lvl = '0;
  logic [60:0] ext_en = '0;
  logic [60:0] pad_o, pad_oe, pad_i, nat_i, v, e;
  logic [31:0] dat_o, mm, mx;
  logic ack, smi, acpi_control_interrupt, irq;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  integer seed = 49;
  int num_errors = 0;
  int samples_checked = 0;
  gpm_top u_dut (.CLK(clk), .RESET_N(rst_n), .SUS_RESET_N(sus_n), .MOBILE(mobile), .WELL_SUS(wsus),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(4'hf), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PAD_I(pad_i), .PAD_O(pad_o), .PAD_OE(pad_oe), .NATIVE_O(nat_o),
    .NATIVE_OE(nat_oe), .NATIVE_I(nat_i), .MEM_ACTIVITY(mem_act), .SYSTEM_MGMT_INTERRUPT(smi),
    .ACPI_CONTROL_INTERRUPT(acpi_control_interrupt), .IRQ(irq));
  gpm_board u_board (.pad_o(pad_o), .pad_oe(pad_oe), .ext_lvl(ext_lvl), .ext_en(ext_en), .pad_i(pad_i));
  always #5 clk = ~clk;
  // read answers are matched against the oldest pending note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      mm = msk_q.pop_front();
      mx = exp_q.pop_front();
      `CHK(dat_o & mm, mx)
    end
  end
  function automatic logic [60:0] rnd61();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    return r[60:0];
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) num_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back(x & m);
    msk_q.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic rd61(input logic [7:0] a, input logic [60:0] x);
    rd(a, x[31:0], 32'hffff_ffff);
    rd(a + 8'h04, {3'b000, x[60:32]}, 32'h1fff_ffff);
  endtask
  task automatic wr61(input logic [7:0] a, input logic [60:0] x);
    wb(1'b1, a, x[31:0]);
    wb(1'b1, a + 8'h04, {3'b000, x[60:32]});
  endtask
  task automatic chk_out(input logic [2:0] x, input logic [2:0] m);
    @(negedge clk);
    `CHK({acpi_control_interrupt, smi, irq} & m, x)
    @(posedge clk);
  endtask
  task automatic do_reset(input logic mob);
    rst_n <= 1'b0;
    sus_n <= 1'b0;
    mobile <= mob;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    sus_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    wsus = rnd61();
    nat_o = rnd61();
    v = rnd61() & `GPM_STRAP_MASK;
    ext_lvl = v; // strap levels stand well before reset is released
    ext_en = `GPM_STRAP_MASK;
    do_reset(1'b0);
    ext_lvl <= ~v;
    rd(`GPM_STRAP, {26'h0, v[58], v[55], v[53], v[51], v[49], v[20]}, 32'hffff_ffff);
    rd61(`GPM_SEL_LO, `GPM_SEL_RST_DT);
    rd61(`GPM_DIR_LO, `GPM_DIR_RST);
    ext_en <= '0;
    nat_oe <= ~`GPM_OD_MASK;
    wr61(`GPM_SEL_LO, {61{1'b1}});
    wr61(`GPM_DIR_LO, 61'h0);
    e = rnd61();
    e[24] = 1'b0;
    wr61(`GPM_LVL_LO, e);
    for (int p = 0; p < 2; p++) begin
      wb(1'b1, `GPM_PMCFG, 32'(p) << 8);
      wb(1'b1, `GPM_FLMAP, 32'(1 - p) << 8);
      repeat (4) @(posedge clk);
      v = p ? e : {e[60:59], nat_o[58], e[57:27], nat_o[26], e[25:0]};
      rd61(`GPM_IN_LO, v);
    end
    mem_act <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`GPM_IN_LO, 32'h0100_0000, 32'h0100_0000);
    mem_act <= 1'b0;
    v = rnd61();
    ext_lvl <= v;
    ext_en <= {61{1'b1}};
    wr61(`GPM_DIR_LO, {61{1'b1}});
    repeat (4) @(posedge clk);
    rd61(`GPM_IN_LO, v);
    ext_lvl <= '0;
    repeat (5) @(posedge clk);
    wb(1'b1, `GPM_ROUTE, 32'h0000_00ff);
    wb(1'b1, `GPM_EVT_CLR, 32'hffff_ffff);
    wb(1'b1, `GPM_EVT_EN, 32'h0000_ffff);
    ext_lvl <= 61'h1_ffff;
    repeat (6) @(posedge clk);
    rd(`GPM_EVT_STS, 32'h0000_ffff, 32'hffff_ffff);
    chk_out(3'b111, 3'b111);
    wb(1'b1, `GPM_EVT_CLR, 32'h0000_00ff);
    rd(`GPM_EVT_STS, 32'h0000_ff00, 32'hffff_ffff);
    chk_out(3'b011, 3'b111);
    wb(1'b1, `GPM_EVT_EN, 32'h0);
    chk_out(3'b000, 3'b111);
    wr61(`GPM_DIR_LO, `GPM_DIR_RST ^ 61'h0104_0000);
    wb(1'b1, `GPM_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    rd61(`GPM_DIR_LO, `GPM_DIR_RST ^ 61'h0100_0000);
    wr61(`GPM_DIR_LO, ~`GPM_DIR_RST);
    sus_n <= 1'b0;
    repeat (2) @(posedge clk);
    sus_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd61(`GPM_DIR_LO, (wsus & `GPM_DIR_RST) | (~wsus & ~`GPM_DIR_RST));
    wb(1'b1, 8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    do_reset(1'b1);
    rd61(`GPM_SEL_LO, `GPM_SEL_RST_MB);
    rd(`GPM_CTRL, 32'h2, 32'h2);
    repeat (2) @(posedge clk);
    v = ~`GPM_SEL_RST_MB;
    @(negedge clk);
    `CHK(nat_i & v, nat_o & v)
    if (exp_q.size() != 0) num_errors++;
    report_and_stop();
  end
endmodule
